// ===== design/spb_spi_top.sv
// Serial peripheral core with bidirectional pin routing, baud divider and transmit buffer.
// Behaviour
// - Master bidir: master-in unused, master-out is input, or I/O when output enabled.
// - Slave bidir: master-out unused, master-in is input, or I/O when output enabled.
// - Divisor equals preselect plus one times two to the select plus one.
// - Serial clock rate is bus clock over the divisor.
// - All divider bits clear divides by two; 001 gives four, 010 gives eight.
// - In master role a change of either divider field aborts to idle.
// - Preselect in bits 6-4, select in 2-0, others read zero, always accessible.
// - Master starts a waiting byte at once after a transfer ends.
// - Done flag sets half a serial clock after the last edge in master role, at the last falling edge in slave role.
module spb_spi_top (
	input  wire logic       SYS_CLK_IN,
	input  wire logic       RSTN_IN,
	input  wire logic [7:0] ADDR_IN,
	input  wire logic [7:0] WDATA_IN,
	input  wire logic       WR_IN,
	input  wire logic       RD_IN,
	output logic      [7:0] RDATA_OUT,
	input  wire logic       MOSI_IN,
	output logic            MOSI_OUT,
	output logic            MOSI_OE_OUT,
	input  wire logic       MISO_IN,
	output logic            MISO_OUT,
	output logic            MISO_OE_OUT,
	input  wire logic       SCK_IN,
	output logic            SCK_OUT,
	output logic            SCK_OE_OUT,
	input  wire logic       SS_N_IN
);
	logic [3:0]                 ctrl;
	logic [7:0]                 baud;
	logic                       done;
	logic [7:0]                 rx_byte;
	spb_pkg::spb_state_e        state;
	spb_pkg::spb_state_e        next_state;
	logic [7:0]                 sh;
	logic [7:0]                 next_sh;
	logic [2:0]                 bit_cnt;
	logic [2:0]                 next_cnt;
	logic                       rx_bit;
	logic                       next_rxb;
	logic                       sck_q;
	logic                       next_sck;
	logic                       xfer_done;
	logic                       pop;
	logic [3:0]                 sync1;
	logic [3:0]                 sync2;
	logic                       sck_d;
	logic                       ssn_d;
	logic                       tick;
	logic                       fifo_v;
	logic                       fifo_rdy;
	logic [7:0]                 fifo_d;

	// Pins from the far party pass two flops before any logic looks at them.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
				if (!RSTN_IN) begin
					sync1[gi] <= (gi == spb_pkg::SPB_PIN_SSN) ? 1'b1 : 1'b0;
					sync2[gi] <= (gi == spb_pkg::SPB_PIN_SSN) ? 1'b1 : 1'b0;
				end else begin
					sync1[gi] <= (gi == spb_pkg::SPB_PIN_MOSI) ? MOSI_IN :
						(gi == spb_pkg::SPB_PIN_MISO) ? MISO_IN :
						(gi == spb_pkg::SPB_PIN_SCK) ? SCK_IN : SS_N_IN;
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	wire       s_mosi   = sync2[spb_pkg::SPB_PIN_MOSI];
	wire       s_miso   = sync2[spb_pkg::SPB_PIN_MISO];
	wire       s_sck    = sync2[spb_pkg::SPB_PIN_SCK];
	wire       s_ssn    = sync2[spb_pkg::SPB_PIN_SSN];
	wire       sck_rise = s_sck && !sck_d;
	wire       sck_fall = !s_sck && sck_d;
	wire       ss_fall  = !s_ssn && ssn_d;

	wire       enable   = ctrl[spb_pkg::SPB_CTRL_EN];
	wire       master   = ctrl[spb_pkg::SPB_CTRL_MST];
	wire       bidir    = ctrl[spb_pkg::SPB_CTRL_BIDIR];
	wire       boe      = ctrl[spb_pkg::SPB_CTRL_BOE];
	wire [2:0] presel   = baud[spb_pkg::SPB_PRESEL_LSB +: 3];
	wire [2:0] sel      = baud[spb_pkg::SPB_SEL_LSB +: 3];

	wire       wr_ctrl  = WR_IN && (ADDR_IN == spb_pkg::SPB_CTRL_ADDR);
	wire       wr_baud  = WR_IN && (ADDR_IN == spb_pkg::SPB_BAUD_ADDR);
	wire       wr_stat  = WR_IN && (ADDR_IN == spb_pkg::SPB_STAT_ADDR);
	wire       wr_data  = WR_IN && (ADDR_IN == spb_pkg::SPB_DATA_ADDR);
	// reserved bits are dropped on write so they always read zero.
	wire [7:0] baud_new = WDATA_IN & spb_pkg::SPB_BAUD_MASK;
	// only a real change of a divider field aborts, and only in master role.
	wire       abort    = master && wr_baud && (baud_new != baud);
	wire       clr_done = wr_stat && WDATA_IN[spb_pkg::SPB_STAT_DONE];

	// bidir master listens on master-out; normal master listens on master-in.
	wire       m_din    = bidir ? s_mosi : s_miso;
	// bidir slave listens on master-in; normal slave listens on master-out.
	wire       s_din    = bidir ? s_miso : s_mosi;
	wire       din      = master ? m_din : s_din;
	wire [7:0] got_byte = master ? sh : {sh[6:0], rx_bit};
	wire       busy     = (state != spb_pkg::SPB_IDLE) || (!master && enable && !s_ssn);

	wire [7:0] stat_rd  = {5'h00, !fifo_rdy, busy, done};
	wire [7:0] rd_mux   = (ADDR_IN == spb_pkg::SPB_CTRL_ADDR) ? {4'h0, ctrl} :
		(ADDR_IN == spb_pkg::SPB_BAUD_ADDR) ? baud :
		(ADDR_IN == spb_pkg::SPB_STAT_ADDR) ? stat_rd :
		(ADDR_IN == spb_pkg::SPB_DATA_ADDR) ? rx_byte : 8'h00;

	// A full buffer refuses the write; software must watch the full status bit.
	spb_fifo2 #(
		.WIDTH (spb_pkg::SPB_WORD_W),
		.DEPTH (spb_pkg::SPB_BUF_DEPTH)
	) u_buf (
		.clk_in        (SYS_CLK_IN),
		.rstn_in       (RSTN_IN),
		.in_valid_in   (wr_data),
		.in_ready_out  (fifo_rdy),
		.in_data_in    (WDATA_IN),
		.out_valid_out (fifo_v),
		.out_ready_in  (pop),
		.out_data_out  (fifo_d)
	);

	// the divider only runs while a master transfer is under way.
	spb_baud_gen u_baud (
		.clk_in    (SYS_CLK_IN),
		.rstn_in   (RSTN_IN),
		.run_in    (master && enable && (state != spb_pkg::SPB_IDLE)),
		.presel_in (presel),
		.sel_in    (sel),
		.tick_out  (tick)
	);

	always_comb begin
		next_state = state;
		next_sh    = sh;
		next_cnt   = bit_cnt;
		next_rxb   = rx_bit;
		next_sck   = sck_q;
		xfer_done  = 1'b0;
		pop        = 1'b0;
		if (!enable || abort) begin
			// abort drops the clock low and returns to idle.
			next_state = spb_pkg::SPB_IDLE;
			next_sck   = 1'b0;
			next_cnt   = 3'h0;
		end else if (master) begin
			case (state)
				spb_pkg::SPB_IDLE: begin
					if (fifo_v) begin
						pop        = 1'b1;
						next_state = spb_pkg::SPB_SHIFT;
						next_sh    = fifo_d;
						next_cnt   = 3'h0;
					end
				end
				spb_pkg::SPB_SHIFT: begin
					if (tick && !sck_q) begin
						next_sck = 1'b1;
						next_rxb = din;
					end else if (tick) begin
						next_sck = 1'b0;
						next_sh  = {sh[6:0], rx_bit};
						next_cnt = bit_cnt + 3'h1;
						if (bit_cnt == spb_pkg::SPB_LAST_BIT) begin
							next_state = spb_pkg::SPB_TAIL;
						end
					end
				end
				spb_pkg::SPB_TAIL: begin
					// one half period after the last falling edge the byte is done.
					if (tick) begin
						xfer_done  = 1'b1;
						next_state = spb_pkg::SPB_IDLE;
						// a waiting byte starts with no idle gap.
						if (fifo_v) begin
							pop        = 1'b1;
							next_state = spb_pkg::SPB_SHIFT;
							next_sh    = fifo_d;
							next_cnt   = 3'h0;
						end
					end
				end
				default: begin
					next_state = spb_pkg::SPB_IDLE;
				end
			endcase
		end else begin
			next_state = spb_pkg::SPB_IDLE;
			next_sck   = 1'b0;
			if (s_ssn) begin
				next_cnt = 3'h0;
			end else if (ss_fall) begin
				next_cnt = 3'h0;
				pop      = fifo_v;
				next_sh  = fifo_v ? fifo_d : sh;
			end else if (sck_rise) begin
				next_rxb = din;
			end else if (sck_fall) begin
				next_sh  = {sh[6:0], rx_bit};
				next_cnt = bit_cnt + 3'h1;
				// the bit count wraps per byte, so select may stay low throughout.
				if (bit_cnt == spb_pkg::SPB_LAST_BIT) begin
					xfer_done = 1'b1;
					pop       = fifo_v;
					next_sh   = fifo_v ? fifo_d : {sh[6:0], rx_bit};
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state   <= spb_pkg::SPB_IDLE;
			sh      <= 8'h00;
			bit_cnt <= 3'h0;
			rx_bit  <= 1'b0;
			sck_q   <= 1'b0;
			sck_d   <= 1'b0;
			ssn_d   <= 1'b1;
		end else begin
			state   <= next_state;
			sh      <= next_sh;
			bit_cnt <= next_cnt;
			rx_bit  <= next_rxb;
			sck_q   <= next_sck;
			sck_d   <= s_sck;
			ssn_d   <= s_ssn;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ctrl      <= spb_pkg::SPB_CTRL_RST;
			baud      <= spb_pkg::SPB_BAUD_RST;
			done      <= 1'b0;
			rx_byte   <= 8'h00;
			RDATA_OUT <= 8'h00;
		end else begin
			ctrl      <= wr_ctrl ? WDATA_IN[3:0] : ctrl;
			// the divider register accepts writes at any time.
			baud      <= wr_baud ? baud_new : baud;
			// a completion in the clearing cycle still leaves the flag set.
			done      <= xfer_done || (done && !clr_done);
			rx_byte   <= xfer_done ? got_byte : rx_byte;
			RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
		end
	end

	// Pin drivers are registered so that no decode glitch reaches the pads.
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			MOSI_OUT    <= 1'b0;
			MISO_OUT    <= 1'b0;
			MOSI_OE_OUT <= 1'b0;
			MISO_OE_OUT <= 1'b0;
			SCK_OUT     <= 1'b0;
			SCK_OE_OUT  <= 1'b0;
		end else begin
			MOSI_OUT    <= sh[7];
			MISO_OUT    <= sh[7];
			// master drives master-out unless bidir with output enable low.
			MOSI_OE_OUT <= enable && master && (!bidir || boe);
			// slave drives master-in while selected, unless bidir input only.
			MISO_OE_OUT <= enable && !master && !s_ssn && (!bidir || boe);
			SCK_OUT     <= sck_q;
			SCK_OE_OUT  <= enable && master;
		end
	end

	a_bidir_master_in : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(enable && master && bidir && !boe && !wr_ctrl) |=> (!MOSI_OE_OUT && !MISO_OE_OUT))
		else $error("Bidir master drives a pin with output enable low.");

	a_bidir_slave_io : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(enable && !master && bidir && boe && !s_ssn && !wr_ctrl)
		|=> (MISO_OE_OUT && !MOSI_OE_OUT))
		else $error("Bidir slave must drive master-in only.");

	a_normal_pins : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(enable && master && !bidir && !wr_ctrl) |=> (MOSI_OE_OUT && !MISO_OE_OUT))
		else $error("Normal master must drive master-out only.");

	a_abort_idle : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		abort |=> (state == spb_pkg::SPB_IDLE) && !sck_q)
		else $error("Divider change did not abort the transfer.");

	a_baud_reserved : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(RD_IN && ADDR_IN == spb_pkg::SPB_BAUD_ADDR)
		|=> (RDATA_OUT[7] == 1'b0) && (RDATA_OUT[3] == 1'b0))
		else $error("Reserved divider bits read non-zero.");

	a_back_to_back : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(enable && master && !abort && state == spb_pkg::SPB_TAIL && tick && fifo_v)
		|=> state == spb_pkg::SPB_SHIFT && bit_cnt == 3'h0)
		else $error("Waiting byte not started at once.");

	a_done_after_tail : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(enable && master && !abort && state == spb_pkg::SPB_TAIL && tick) |=> done)
		else $error("Done flag missing after the last half period.");

	a_sck_only_busy : assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
		(state == spb_pkg::SPB_IDLE) |-> ##1 $stable(sck_q) || !sck_q)
		else $error("Serial clock moved while idle.");
endmodule

// ===== inc/spb_pkg.sv
// Shared constants for the serial peripheral pin routing and baud generator block.
package spb_pkg;
	localparam logic [7:0] SPB_CTRL_ADDR  = 8'he8;
	localparam logic [7:0] SPB_BAUD_ADDR  = 8'hea;
	localparam logic [7:0] SPB_STAT_ADDR  = 8'heb;
	localparam logic [7:0] SPB_DATA_ADDR  = 8'hed;
	localparam logic [3:0] SPB_CTRL_RST   = 4'h0;
	localparam logic [7:0] SPB_BAUD_RST   = 8'h00;
	localparam logic [7:0] SPB_BAUD_MASK  = 8'h77;
	localparam int         SPB_CTRL_EN    = 0;
	localparam int         SPB_CTRL_MST   = 1;
	localparam int         SPB_CTRL_BIDIR = 2;
	localparam int         SPB_CTRL_BOE   = 3;
	localparam int         SPB_PRESEL_LSB = 4;
	localparam int         SPB_SEL_LSB    = 0;
	localparam int         SPB_STAT_DONE  = 0;
	localparam int         SPB_STAT_BUSY  = 1;
	localparam int         SPB_STAT_FULL  = 2;
	localparam int         SPB_WORD_W     = 8;
	localparam int         SPB_BUF_DEPTH  = 2;
	localparam logic [2:0] SPB_LAST_BIT   = 3'h7;
	localparam int         SPB_PIN_MOSI   = 0;
	localparam int         SPB_PIN_MISO   = 1;
	localparam int         SPB_PIN_SCK    = 2;
	localparam int         SPB_PIN_SSN    = 3;
	typedef enum logic [1:0] {SPB_IDLE, SPB_SHIFT, SPB_TAIL} spb_state_e;
endpackage

// ===== design/spb_fifo2.sv
// Two-entry buffer with valid and ready on both sides for transmit words.
module spb_fifo2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr;
	logic [PW-1:0]    rptr;
	logic [PW:0]      cnt;
	wire              push = in_valid_in && in_ready_out;
	wire              pop  = out_valid_out && out_ready_in;

	// The count is one bit wider than the pointers, so a full buffer is told apart from an empty one.
	assign in_ready_out  = cnt != (PW+1)'(DEPTH);
	assign out_valid_out = cnt != '0;
	assign out_data_out  = mem[rptr];

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wptr] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wptr <= '0;
			rptr <= '0;
			cnt  <= '0;
		end else begin
			if (push) begin
				wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
			end
			cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	a_buf_no_overflow : assert property (@(posedge clk_in) disable iff (!rstn_in)
		cnt <= (PW+1)'(DEPTH)) else $error("Buffer count beyond depth.");
endmodule

// ===== design/spb_baud_gen.sv
// Preselect counter followed by a power-of-two stage, giving half serial clock ticks.
module spb_baud_gen (
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       run_in,
	input  wire logic [2:0] presel_in,
	input  wire logic [2:0] sel_in,
	output logic            tick_out
);
	logic [2:0] pc;
	logic [6:0] qc;
	logic [9:0] gap;
	// the pow2 stage ends at two to the select value minus one, halving the divisor.
	wire  [6:0] qmax    = 7'((8'h01 << sel_in) - 8'h01);
	wire  [9:0] half_m1 = 10'(({7'h00, presel_in} + 10'h001) << sel_in) - 10'h001;

	// ticks come only while the master engine runs.
	assign tick_out = run_in && (pc == presel_in) && (qc == qmax);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pc  <= 3'h0;
			qc  <= 7'h00;
			gap <= 10'h000;
		end else if (!run_in) begin
			pc  <= 3'h0;
			qc  <= 7'h00;
			gap <= 10'h000;
		end else begin
			pc  <= (pc == presel_in) ? 3'h0 : pc + 3'h1;
			qc  <= (pc != presel_in) ? qc : (tick_out ? 7'h00 : qc + 7'h01);
			gap <= tick_out ? 10'h000 : gap + 10'h001;
		end
	end

	a_half_period_len : assert property (@(posedge clk_in) disable iff (!rstn_in)
		tick_out |-> gap == half_m1) else $error("Half period length differs from divisor.");
	a_reset_div_two : assert property (@(posedge clk_in) disable iff (!rstn_in)
		(run_in && presel_in == 3'h0 && sel_in == 3'h0) |-> tick_out)
		else $error("Zero setting must tick every cycle.");
endmodule

// ===== verification/spb_partner.sv
// Model of the far serial device: slave to the block's master, master to its slave.
module spb_partner (
	input  wire logic       sck_in,
	input  wire logic       sdi_in,
	output logic            sdo_out,
	output logic            sck_out,
	output logic            ss_n_out,
	output logic      [7:0] rx_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	initial begin
		sh = 8'h00;
		rx_out = 8'h00;
		sck_out = 1'b0;
		ss_n_out = 1'b1;
	end
	assign sdo_out = sh[7];
	always @(posedge sck_in) begin
		rx_out <= {rx_out[6:0], sdi_in};
	end
	// Past the last bit the line keeps changing, so a stale level is never seen as data.
	always @(negedge sck_in) begin
		sh <= {sh[6:0], ~sh[7]};
	end
	task automatic send(input logic [7:0] b, input int half);
		#(half) sh = b;
		repeat (8) begin
			#(half) sck_out = 1'b1;
			#(half) sck_out = 1'b0;
		end
	endtask
endmodule

// ===== verification/spi_pin_config_and_baud_gen_test.sv
// Self-checking bench for the serial pin routing and baud generator block.
module spi_pin_config_and_baud_gen_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic [7:0]  rdata;
	logic        mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe;
	logic        p_sdo, p_sck, p_ss_n;
	logic [7:0]  p_rx;
	logic        pm = 1'b0;
	logic        bd = 1'b0;
	logic        flip = 1'b0;
	logic [31:0] seed = 32'h4e2ae906;
	int          cyc = 0;
	int          n_fail = 0;
	int          compares = 0;
	// An undriven line toggles every cycle instead of holding its last level.
	wire mosi_w = mosi_oe ? mosi_o : ((pm ^ bd) ? p_sdo : flip);
	wire miso_w = miso_oe ? miso_o : (!(pm ^ bd) ? p_sdo : flip);
	wire sck_w  = sck_oe ? sck_o : (pm ? p_sck : flip);
	wire p_sdi  = pm ? miso_w : mosi_w;
	spb_spi_top dut_u (
		.SYS_CLK_IN  (clk),
		.RSTN_IN     (rstn),
		.ADDR_IN     (addr),
		.WDATA_IN    (wdata),
		.WR_IN       (wr_s),
		.RD_IN       (rd_s),
		.RDATA_OUT   (rdata),
		.MOSI_IN     (mosi_w),
		.MOSI_OUT    (mosi_o),
		.MOSI_OE_OUT (mosi_oe),
		.MISO_IN     (miso_w),
		.MISO_OUT    (miso_o),
		.MISO_OE_OUT (miso_oe),
		.SCK_IN      (sck_w),
		.SCK_OUT     (sck_o),
		.SCK_OE_OUT  (sck_oe),
		.SS_N_IN     (p_ss_n)
	);
	spb_partner part_u (
		.sck_in   (sck_w),
		.sdi_in   (p_sdi),
		.sdo_out  (p_sdo),
		.sck_out  (p_sck),
		.ss_n_out (p_ss_n),
		.rx_out   (p_rx)
	);
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		flip <= ~flip;
	end
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	function automatic logic [7:0] oe_exp(input logic [3:0] c);
		return {6'h00, c[1] & (!c[2] | c[3]), !c[1] & (!c[2] | c[3])};
	endfunction
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic hang;
		n_fail++;
		$display("[FAIL] %0t wait ran out", $time);
		end_of_test();
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkn(input int g, input int lo, input int hi);
		compares++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("[FAIL] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_lvl(input logic lvl, output int t);
		int n;
		n = 0;
		while (sck_o !== lvl && n < 5000) begin
			@(posedge clk);
			#1 n++;
		end
		if (n == 5000) hang();
		t = cyc;
	endtask
	task automatic wait_done(output int t);
		logic [7:0] d;
		int n;
		d = 8'h00;
		n = 0;
		while (d[0] !== 1'b1 && n < 200) begin
			rd(spb_pkg::SPB_STAT_ADDR, d);
			n++;
		end
		if (n == 200) hang();
		t = cyc;
	endtask
	task automatic xfer(input logic [3:0] c, input logic [2:0] p, input logic [2:0] s,
		input int n);
		logic [7:0] a[2];
		logic [7:0] b[2];
		logic [7:0] d;
		int h, dv, r1, f, t;
		h = int'(p + 1) << s;
		dv = int'(p + 1) * (2 ** (int'(s) + 1));
		for (int i = 0; i < 2; i++) begin
			a[i] = rnd();
			b[i] = rnd();
		end
		pm = !c[1];
		bd = c[2];
		wr(spb_pkg::SPB_BAUD_ADDR, {1'b0, p, 1'b0, s});
		wr(spb_pkg::SPB_CTRL_ADDR, {4'h0, c});
		repeat (2) @(posedge clk);
		#1 part_u.sh = b[0];
		for (int i = 0; i < n; i++) wr(spb_pkg::SPB_DATA_ADDR, a[i]);
		if (c[1]) begin
			for (int k = 0; k < 8 * n; k++) begin
				wait_lvl(1'b1, t);
				if (k == 0) r1 = t;
				if (k == 0) chk(oe_exp(c), {6'h00, mosi_oe, miso_oe});
				if (k == 1) chkn(t - r1, dv, dv);
				if (k == 8) chkn(t - f, 1, 2 * h + 4);
				wait_lvl(1'b0, f);
				if (k == 7) part_u.sh = b[1];
			end
			if (n == 1 && h >= 8) rd(spb_pkg::SPB_STAT_ADDR, d);
			if (n == 1 && h >= 8) chk(d & 8'h01, 8'h00);
			wait_done(t);
			if (n == 1) chkn(t - f, h, h + 6);
		end else begin
			part_u.ss_n_out = 1'b0;
			for (int i = 0; i < n; i++) part_u.send(b[i], 200);
			chk(oe_exp(c), {6'h00, mosi_oe, miso_oe});
			wait_done(t);
			part_u.ss_n_out = 1'b1;
		end
		if (h >= 4 && !(c[2] && c[3])) rd(spb_pkg::SPB_DATA_ADDR, d);
		if (h >= 4 && !(c[2] && c[3])) chk(d, b[n - 1]);
		if (h >= 4 && (!c[2] || c[3])) chk(p_rx, a[n - 1]);
		wr(spb_pkg::SPB_STAT_ADDR, 8'h01);
		wr(spb_pkg::SPB_CTRL_ADDR, 8'h00);
	endtask
	initial begin
		logic [7:0] v;
		logic [7:0] d;
		int t;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(spb_pkg::SPB_BAUD_ADDR, d);
		chk(d, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			wr(spb_pkg::SPB_BAUD_ADDR, v);
			wr(8'h00, ~v);
			rd(8'h00, d);
			chk(d, 8'h00);
			rd(spb_pkg::SPB_BAUD_ADDR, d);
			chk(d, v & 8'h77);
		end
		for (int i = 0; i < 3; i++) xfer(4'h3, 3'h0, 3'(i), 1);
		for (int i = 0; i < 3; i++) begin
			v = rnd();
			xfer(4'h3, v[6:4], {1'b0, v[1:0]}, 1);
		end
		xfer(4'h3, 3'h1, 3'h1, 2);
		xfer(4'h7, 3'h0, 3'h3, 1);
		xfer(4'hf, 3'h0, 3'h3, 1);
		wr(spb_pkg::SPB_BAUD_ADDR, 8'h72);
		wr(spb_pkg::SPB_CTRL_ADDR, 8'h03);
		wr(spb_pkg::SPB_DATA_ADDR, 8'h3c);
		wait_lvl(1'b1, t);
		wr(spb_pkg::SPB_BAUD_ADDR, 8'h73);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, sck_o}, 8'h00);
		repeat (100) @(posedge clk);
		#1 chk({7'h00, sck_o}, 8'h00);
		rd(spb_pkg::SPB_STAT_ADDR, d);
		chk(d & 8'h03, 8'h00);
		wr(spb_pkg::SPB_CTRL_ADDR, 8'h00);
		xfer(4'h1, 3'h0, 3'h2, 2);
		xfer(4'h5, 3'h0, 3'h2, 1);
		xfer(4'hd, 3'h0, 3'h2, 1);
		end_of_test();
	end
endmodule
